// ===== src/msc_pkg.sv
package msc_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [5:0] OFS_CONFIG = 6'h00;
  localparam logic [5:0] OFS_PULLUP0 = 6'h04;
  localparam logic [5:0] OFS_INT_DELAY = 6'h14;
  localparam logic [5:0] OFS_WATCHDOG_CONTROL_STATUS = 6'h18;
  localparam logic [5:0] OFS_IRQ_STATUS = 6'h1c;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h20;
  localparam logic [5:0] OFS_POWER_CTRL = 6'h24;

  // Field positions.
  localparam int unsigned CFG_BOOT_MAP_BIT = 0;
  localparam int unsigned CFG_EXT_SRC_BIT = 6;
  localparam int unsigned CFG_CLK_RATE_BIT = 7;
  localparam int unsigned WD_KICK_BIT = 0;
  localparam int unsigned WD_FLAG_BIT = 6;
  localparam int unsigned WD_RUN_BIT = 7;
  localparam int unsigned PWR_IDLE_BIT = 0;
  localparam int unsigned IRQ_WDT_BIT = 0;
  localparam int unsigned IRQ_IDLE_EXIT_BIT = 1;
  localparam int unsigned IRQ_W = 2;

  // Values after reset.
  localparam logic [7:0] PULLUP_RST = 8'h00;
  localparam logic [3:0] INT_DELAY_RST = 4'h2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // Watchdog counter.
  localparam int unsigned WD_CNT_W = 5;
  localparam logic [4:0] WD_CNT_MAX = 5'h1f;

  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned IDLE_EXIT_NS = 400000;
  localparam int unsigned IDLE_EXIT_CYCLES = (IDLE_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Memory map.
  localparam logic [15:0] ROM_BYTES = 16'h1800;
  localparam logic [15:0] RAM_BYTES = 16'h2000;
  localparam logic [15:0] ROM_HIGH_BASE = 16'h8000;
  localparam logic [15:0] ROM_HIGH_LIMIT = ROM_HIGH_BASE + ROM_BYTES;

  localparam int unsigned NUM_PORTS = 4;

  function automatic logic [5:0] pullup_ofs(input logic [1:0] port);
    return OFS_PULLUP0 + {2'h0, port, 2'h0};
  endfunction

endpackage

// ===== src/msc_wdt_if.sv
`timescale 1ns/1ps
`default_nettype none

interface msc_wdt_if;
  logic run;
  logic idle;
  logic kick;
  logic clear;
  logic tick;
  logic timeout;
  logic [msc_pkg::WD_CNT_W-1:0] count;

  modport ctrl (
    output run, idle, kick, clear, tick,
    input timeout, count
  );

  modport wdt (
    input run, idle, kick, clear, tick,
    output timeout, count
  );
endinterface

`default_nettype wire

// ===== src/msc_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

module msc_watchdog (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Control side.
  msc_wdt_if.wdt wd
);
  import msc_pkg::*;

  logic [WD_CNT_W-1:0] count_reg;
  logic timeout_reg;
  logic step;

  assign step = wd.run && !wd.idle && wd.tick && !wd.kick && !wd.clear;
  assign wd.count = count_reg;
  assign wd.timeout = timeout_reg;

  // Counter returns to zero on service or reset, and wraps at expiry.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= '0;
    end else if (wd.kick || wd.clear) begin
      count_reg <= '0;
    end else if (step) begin
      count_reg <= (count_reg == WD_CNT_MAX) ? '0 : count_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= step && (count_reg == WD_CNT_MAX);
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_wdt_idle_hold:
    assert property (wd.idle && !wd.kick && !wd.clear |=> $stable(count_reg) && !timeout_reg)
    else $error("Watchdog moved while idle.");

  a_wdt_kick_zero:
    assert property (wd.kick |=> count_reg == '0 && !timeout_reg)
    else $error("Watchdog not zeroed by service.");

  a_wdt_expiry:
    assert property (timeout_reg |-> $past(count_reg) == WD_CNT_MAX && $past(wd.tick)
      && $past(wd.run) && count_reg == '0)
    else $error("Watchdog timeout without expiry.");

  a_wdt_advance:
    assert property (step && count_reg != WD_CNT_MAX |=> count_reg == $past(count_reg) + 1'b1)
    else $error("Watchdog did not advance on tick.");

endmodule

`default_nettype wire

// ===== src/msc_sysctl.sv
`timescale 1ns/1ps
`default_nettype none

module msc_sysctl #(
  // Arbitrary revision value.
  parameter logic [3:0] REVISION = 4'h5,
  parameter int unsigned IDLE_EXIT_CYCLES = msc_pkg::IDLE_EXIT_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Function reset and millisecond tick, same clock domain.
  input wire logic usb_reset_i,
  input wire logic usb_reset_wd_en_i,
  input wire logic ms_tick_i,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Memory map decode.
  input wire logic [15:0] code_addr_i,
  input wire logic [15:0] xdata_addr_i,
  input wire logic xdata_wr_i,
  output logic code_rom_hit_o,
  output logic code_ram_hit_o,
  output logic xdata_ram_hit_o,
  output logic xdata_ram_wr_en_o,
  // Pins.
  input wire logic port3_pin3_i,
  input wire logic [7:0] port2_i,
  output logic [msc_pkg::NUM_PORTS*8-1:0] pin_pullup_disconnect_o,
  // Controller controls.
  output logic ext_irq_one_o,
  output logic mcu_clk_fast_o,
  output logic [3:0] port2_irq_delay_ms_o,
  output logic idle_flag_o,
  output logic mcu_reset_o,
  output logic irq_o
);
  import msc_pkg::*;

  localparam int unsigned HOLD_W = $clog2(IDLE_EXIT_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(IDLE_EXIT_CYCLES - 1);

  msc_wdt_if wd_bus ();

  // Pin synchronisers.
  logic [7:0] p2_meta_reg;
  logic [7:0] p2_sync_reg;
  logic p33_meta_reg;
  logic p33_sync_reg;

  // Bus state.
  logic ack_reg;
  logic req;
  logic wr_stb;
  logic [7:0] wdata;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Registers.
  logic boot_map_select_reg;
  logic ext_irq_source_select_reg;
  logic clk_fast_reg;
  logic [7:0] pullup_reg [NUM_PORTS];
  logic [3:0] int_delay_reg;
  logic watchdog_run_reg;
  logic watchdog_reset_flag_reg;
  logic idle_flag_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;

  // Interrupt one and idle exit.
  logic ext_irq_one_reg;
  logic [HOLD_W-1:0] hold_cnt_reg;
  logic idle_exit;

  // Memory decode.
  logic code_rom_hit_reg;
  logic code_ram_hit_reg;
  logic xdata_ram_hit_reg;
  logic xdata_ram_wr_en_reg;

  logic wr_cfg;
  logic wr_delay;
  logic wr_watchdog_control_status;
  logic wr_status;
  logic wr_mask;
  logic wr_power;
  logic usb_wd_clear;

  // Two flip-flop synchronisers for the port pins.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p2_meta_reg <= 8'h00;
      p2_sync_reg <= 8'h00;
      p33_meta_reg <= 1'b0;
      p33_sync_reg <= 1'b0;
    end else begin
      p2_meta_reg <= port2_i;
      p2_sync_reg <= p2_meta_reg;
      p33_meta_reg <= port3_pin3_i;
      p33_sync_reg <= p33_meta_reg;
    end
  end

  // Avalon slave: every access waits one cycle, then completes.
  assign req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = req && !ack_reg;
  assign wr_stb = avs_write_i && ack_reg && avs_byteenable_i[0];
  assign wdata = avs_writedata_i[7:0];
  assign avs_readdata_o = {24'h000000, rdata_reg};

  assign wr_cfg = wr_stb && (avs_address_i == OFS_CONFIG);
  assign wr_delay = wr_stb && (avs_address_i == OFS_INT_DELAY);
  assign wr_watchdog_control_status = wr_stb && (avs_address_i == OFS_WATCHDOG_CONTROL_STATUS);
  assign wr_status = wr_stb && (avs_address_i == OFS_IRQ_STATUS);
  assign wr_mask = wr_stb && (avs_address_i == OFS_IRQ_MASK);
  assign wr_power = wr_stb && (avs_address_i == OFS_POWER_CTRL);
  assign usb_wd_clear = usb_reset_i && usb_reset_wd_en_i;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  // Read data; unmapped addresses read zero.
  always_comb begin
    rdata_next = 8'h00;
    unique case (avs_address_i)
      OFS_CONFIG: begin
        rdata_next = {clk_fast_reg, ext_irq_source_select_reg, 1'b0, REVISION,
                      boot_map_select_reg};
      end
      OFS_INT_DELAY: begin
        rdata_next = {4'h0, int_delay_reg};
      end
      OFS_WATCHDOG_CONTROL_STATUS: begin
        rdata_next = {watchdog_run_reg, watchdog_reset_flag_reg, 6'h00};
      end
      OFS_IRQ_STATUS: begin
        rdata_next = {6'h00, irq_status_reg};
      end
      OFS_IRQ_MASK: begin
        rdata_next = {6'h00, irq_mask_reg};
      end
      OFS_POWER_CTRL: begin
        rdata_next = {7'h00, idle_flag_reg};
      end
      default: begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (avs_address_i == pullup_ofs(2'(p))) begin
            rdata_next = pullup_reg[p];
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 8'h00;
    end else if (avs_read_i && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // Configuration register.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boot_map_select_reg <= 1'b0;
    end else if (usb_reset_i) begin
      boot_map_select_reg <= 1'b0;
    end else if (wr_cfg && wdata[CFG_BOOT_MAP_BIT]) begin
      boot_map_select_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_irq_source_select_reg <= 1'b0;
      clk_fast_reg <= 1'b0;
    end else if (wr_cfg) begin
      ext_irq_source_select_reg <= wdata[CFG_EXT_SRC_BIT];
      clk_fast_reg <= wdata[CFG_CLK_RATE_BIT];
    end
  end

  // Pullup control, one register per port.
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_pullup
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        pullup_reg[g] <= PULLUP_RST;
      end else if (wr_stb && (avs_address_i == pullup_ofs(2'(g)))) begin
        pullup_reg[g] <= wdata;
      end
    end
    assign pin_pullup_disconnect_o[g*8 +: 8] = pullup_reg[g];
  end

  // Port 2 interrupt delay.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_delay_reg <= INT_DELAY_RST;
    end else if (wr_delay) begin
      int_delay_reg <= wdata[3:0];
    end
  end

  // Watchdog enable: set by firmware, cleared only by resets or timeout.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      watchdog_run_reg <= 1'b0;
    end else if (wd_bus.timeout || usb_wd_clear) begin
      watchdog_run_reg <= 1'b0;
    end else if (wr_watchdog_control_status && wdata[WD_RUN_BIT]) begin
      watchdog_run_reg <= 1'b1;
    end
  end

  // Watchdog reset flag; a timeout wins over any clear.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      watchdog_reset_flag_reg <= 1'b0;
    end else if (wd_bus.timeout) begin
      watchdog_reset_flag_reg <= 1'b1;
    end else if (usb_reset_i || (wr_watchdog_control_status && wdata[WD_FLAG_BIT])) begin
      watchdog_reset_flag_reg <= 1'b0;
    end
  end

  assign wd_bus.run = watchdog_run_reg;
  assign wd_bus.idle = idle_flag_reg;
  assign wd_bus.kick = wr_watchdog_control_status && wdata[WD_KICK_BIT];
  assign wd_bus.clear = usb_reset_i;
  assign wd_bus.tick = ms_tick_i;

  msc_watchdog u_watchdog (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .wd(wd_bus.wdt)
  );

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mcu_reset_o <= 1'b0;
    end else begin
      mcu_reset_o <= wd_bus.timeout;
    end
  end

  // External interrupt one source.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_irq_one_reg <= 1'b0;
    end else begin
      ext_irq_one_reg <= ext_irq_source_select_reg ? |p2_sync_reg : p33_sync_reg;
    end
  end

  // Counts how long interrupt one has been held.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_cnt_reg <= '0;
    end else if (!ext_irq_one_reg) begin
      hold_cnt_reg <= '0;
    end else if (hold_cnt_reg != HOLD_LAST) begin
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end
  end

  assign idle_exit = idle_flag_reg && ext_irq_one_reg && (hold_cnt_reg == HOLD_LAST);

  // Idle flag; a firmware set in the same cycle wins over the exit.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_flag_reg <= 1'b0;
    end else if (wr_power && wdata[PWR_IDLE_BIT]) begin
      idle_flag_reg <= 1'b1;
    end else if (idle_exit) begin
      idle_flag_reg <= 1'b0;
    end
  end

  // Interrupt status, write one to clear; a new event wins over the clear.
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_status) begin
      irq_status_next = irq_status_reg & ~wdata[IRQ_W-1:0];
    end
    if (wd_bus.timeout) begin
      irq_status_next[IRQ_WDT_BIT] = 1'b1;
    end
    if (idle_exit) begin
      irq_status_next[IRQ_IDLE_EXIT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_status_reg <= IRQ_RST;
      irq_mask_reg <= IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_mask) begin
        irq_mask_reg <= wdata[IRQ_W-1:0];
      end
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Memory map decode, registered.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_rom_hit_reg <= 1'b0;
      code_ram_hit_reg <= 1'b0;
      xdata_ram_hit_reg <= 1'b0;
      xdata_ram_wr_en_reg <= 1'b0;
    end else begin
      code_rom_hit_reg <= (code_addr_i >= ROM_HIGH_BASE && code_addr_i < ROM_HIGH_LIMIT)
        || (!boot_map_select_reg && code_addr_i < ROM_BYTES);
      code_ram_hit_reg <= boot_map_select_reg && code_addr_i < RAM_BYTES;
      xdata_ram_hit_reg <= !boot_map_select_reg && xdata_addr_i < RAM_BYTES;
      xdata_ram_wr_en_reg <= !boot_map_select_reg && xdata_wr_i
        && xdata_addr_i < RAM_BYTES;
    end
  end

  assign code_rom_hit_o = code_rom_hit_reg;
  assign code_ram_hit_o = code_ram_hit_reg;
  assign xdata_ram_hit_o = xdata_ram_hit_reg;
  assign xdata_ram_wr_en_o = xdata_ram_wr_en_reg;
  assign ext_irq_one_o = ext_irq_one_reg;
  assign mcu_clk_fast_o = clk_fast_reg;
  assign port2_irq_delay_ms_o = int_delay_reg;
  assign idle_flag_o = idle_flag_reg;
  assign irq_o = irq_reg;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_boot_map_sticky:
    assert property (boot_map_select_reg && !usb_reset_i |=> boot_map_select_reg)
    else $error("Boot map select cleared without reset.");

  a_boot_map_clear:
    assert property (usb_reset_i |=> !boot_map_select_reg ##1 !boot_map_select_reg
      || $past(wr_cfg))
    else $error("Function reset did not clear boot map.");

  a_code_ram_map:
    assert property (boot_map_select_reg && code_addr_i < RAM_BYTES
      |=> code_ram_hit_o && !code_rom_hit_o && !xdata_ram_wr_en_o)
    else $error("Normal map decode wrong.");

  a_boot_rom_map:
    assert property (!boot_map_select_reg && code_addr_i < ROM_BYTES
      |=> code_rom_hit_o && !code_ram_hit_o)
    else $error("Boot map decode wrong.");

  a_revision_read:
    assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_CONFIG
      |-> avs_readdata_o[4:1] == REVISION && avs_readdata_o[5] == 1'b0)
    else $error("Revision field wrong.");

  a_kick_reads_zero:
    assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_WATCHDOG_CONTROL_STATUS
      |-> avs_readdata_o[5:0] == 6'h00)
    else $error("Watchdog low bits not zero.");

  a_run_sticky:
    assert property (watchdog_run_reg && !wd_bus.timeout && !usb_wd_clear |=> watchdog_run_reg)
    else $error("Watchdog stopped without reset.");

  a_timeout_effects:
    assert property (wd_bus.timeout |=> watchdog_reset_flag_reg && !watchdog_run_reg
      && mcu_reset_o)
    else $error("Timeout effects missing.");

  a_irq_source:
    assert property (ext_irq_one_o == ($past(ext_irq_source_select_reg) ? |$past(p2_sync_reg)
      : $past(p33_sync_reg)))
    else $error("Interrupt one source wrong.");

  a_idle_exit_hold:
    assert property ($fell(idle_flag_reg) |-> $past(hold_cnt_reg) == HOLD_LAST
      && $past(ext_irq_one_reg))
    else $error("Idle left without held interrupt.");

  a_delay_reserved:
    assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_INT_DELAY
      |-> avs_readdata_o[7:4] == 4'h0)
    else $error("Delay reserved bits not zero.");

endmodule

`default_nettype wire

// ===== verif/msc_sysctl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module msc_sysctl_tb_top;
  import msc_pkg::*;

  localparam int unsigned IDLE_N = 20;
  // Arbitrary revision value.
  localparam logic [3:0] REV = 4'h5;

  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic usb_reset_i = 1'b0;
  logic usb_reset_wd_en_i = 1'b0;
  logic ms_tick_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [15:0] code_addr_i = 16'h0;
  logic [15:0] xdata_addr_i = 16'h0;
  logic xdata_wr_i = 1'b0;
  logic code_rom_hit_o, code_ram_hit_o, xdata_ram_hit_o, xdata_ram_wr_en_o;
  logic port3_pin3_i = 1'b0;
  logic [7:0] port2_i = 8'h00;
  logic [31:0] pin_pullup_disconnect_o;
  logic ext_irq_one_o, mcu_clk_fast_o, idle_flag_o, mcu_reset_o, irq_o;
  logic [3:0] port2_irq_delay_ms_o;
  logic [31:0] rdata;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int resets = 0;

  msc_sysctl #(.REVISION(REV), .IDLE_EXIT_CYCLES(IDLE_N)) DUT (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .usb_reset_i(usb_reset_i),
    .usb_reset_wd_en_i(usb_reset_wd_en_i), .ms_tick_i(ms_tick_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .code_addr_i(code_addr_i), .xdata_addr_i(xdata_addr_i), .xdata_wr_i(xdata_wr_i),
    .code_rom_hit_o(code_rom_hit_o), .code_ram_hit_o(code_ram_hit_o),
    .xdata_ram_hit_o(xdata_ram_hit_o), .xdata_ram_wr_en_o(xdata_ram_wr_en_o),
    .port3_pin3_i(port3_pin3_i), .port2_i(port2_i),
    .pin_pullup_disconnect_o(pin_pullup_disconnect_o), .ext_irq_one_o(ext_irq_one_o),
    .mcu_clk_fast_o(mcu_clk_fast_o), .port2_irq_delay_ms_o(port2_irq_delay_ms_o),
    .idle_flag_o(idle_flag_o), .mcu_reset_o(mcu_reset_o), .irq_o(irq_o)
  );

  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end

  // Counts controller reset pulses and cuts a hang short.
  always @(negedge core_clk_i) begin
    cycles++;
    if (mcu_reset_o === 1'b1) begin
      resets++;
    end
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= ~w;
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdata, {24'h0, e});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      ms_tick_i <= 1'b1;
      @(posedge core_clk_i);
      ms_tick_i <= 1'b0;
    end
  endtask

  task automatic usb(input logic en);
    @(posedge core_clk_i);
    usb_reset_i <= 1'b1;
    usb_reset_wd_en_i <= en;
    @(posedge core_clk_i);
    usb_reset_i <= 1'b0;
    usb_reset_wd_en_i <= 1'b0;
  endtask

  // Expected is {rom hit, code ram hit, data ram hit, data ram write enable}.
  task automatic map(input logic [15:0] ca, input logic [15:0] xa, input logic [3:0] e);
    @(posedge core_clk_i);
    code_addr_i <= ca;
    xdata_addr_i <= xa;
    xdata_wr_i <= 1'b1;
    settle(1);
    chk({28'h0, code_rom_hit_o, code_ram_hit_o, xdata_ram_hit_o, xdata_ram_wr_en_o},
        {28'h0, e});
  endtask

  task automatic t_reset();
    rd_chk(OFS_CONFIG, {3'h0, REV, 1'b0});
    rd_chk(OFS_INT_DELAY, 8'h02);
    rd_chk(OFS_WATCHDOG_CONTROL_STATUS, 8'h00);
    chk(pin_pullup_disconnect_o, 32'h0);
    chk({28'h0, port2_irq_delay_ms_o}, 32'h2);
    chk({31'h0, mcu_clk_fast_o}, 32'h0);
  endtask

  task automatic t_config_map();
    map(16'h0000, 16'h0000, 4'b1011);
    map(16'h8000, 16'h1fff, 4'b1011);
    wr(OFS_CONFIG, 8'hff);
    rd_chk(OFS_CONFIG, {3'h6, REV, 1'b1});
    chk({31'h0, mcu_clk_fast_o}, 32'h1);
    map(16'h0000, 16'h0000, 4'b0100);
    map(16'h8000, 16'h1fff, 4'b1000);
    wr(OFS_CONFIG, 8'h00);
    rd_chk(OFS_CONFIG, {3'h0, REV, 1'b1});
    usb(1'b0);
    rd_chk(OFS_CONFIG, {3'h0, REV, 1'b0});
  endtask

  task automatic t_pullup_delay();
    logic [7:0] pat;
    for (int p = 0; p < 4; p++) begin
      pat = 8'h96 ^ 8'(p);
      wr(OFS_PULLUP0 + 6'(4 * p), pat);
      rd_chk(OFS_PULLUP0 + 6'(4 * p), pat);
      chk({24'h0, pin_pullup_disconnect_o[8 * p +: 8]}, {24'h0, pat});
    end
    wr(OFS_INT_DELAY, 8'hff);
    rd_chk(OFS_INT_DELAY, 8'h0f);
    chk({28'h0, port2_irq_delay_ms_o}, 32'hf);
  endtask

  task automatic t_irq_src();
    @(posedge core_clk_i);
    port2_i <= 8'h10;
    settle(5);
    chk({31'h0, ext_irq_one_o}, 32'h0);
    @(posedge core_clk_i);
    port3_pin3_i <= 1'b1;
    settle(5);
    chk({31'h0, ext_irq_one_o}, 32'h1);
    wr(OFS_CONFIG, 8'h40);
    port3_pin3_i <= 1'b0;
    settle(5);
    chk({31'h0, ext_irq_one_o}, 32'h1);
    @(posedge core_clk_i);
    port2_i <= 8'h00;
    port3_pin3_i <= 1'b1;
    settle(5);
    chk({31'h0, ext_irq_one_o}, 32'h0);
    @(posedge core_clk_i);
    port3_pin3_i <= 1'b0;
    wr(OFS_CONFIG, 8'h00);
  endtask

  task automatic t_wdt();
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_WATCHDOG_CONTROL_STATUS, 8'h80);
    rd_chk(OFS_WATCHDOG_CONTROL_STATUS, 8'h80);
    tick(20);
    wr(OFS_WATCHDOG_CONTROL_STATUS, 8'h01);
    rd_chk(OFS_WATCHDOG_CONTROL_STATUS, 8'h80);
    wr(OFS_WATCHDOG_CONTROL_STATUS, 8'h00);
    tick(31);
    settle(3);
    chk(32'(resets), 32'h0);
    tick(1);
    settle(3);
    chk(32'(resets), 32'h1);
    rd_chk(OFS_WATCHDOG_CONTROL_STATUS, 8'h40);
    chk({31'h0, irq_o}, 32'h1);
    wr(OFS_IRQ_STATUS, 8'h01);
    settle(2);
    chk({31'h0, irq_o}, 32'h0);
    wr(OFS_WATCHDOG_CONTROL_STATUS, 8'h00);
    rd_chk(OFS_WATCHDOG_CONTROL_STATUS, 8'h40);
    wr(OFS_WATCHDOG_CONTROL_STATUS, 8'h40);
    rd_chk(OFS_WATCHDOG_CONTROL_STATUS, 8'h00);
  endtask

  task automatic t_idle();
    wr(OFS_WATCHDOG_CONTROL_STATUS, 8'h81);
    wr(OFS_POWER_CTRL, 8'h01);
    wr(OFS_POWER_CTRL, 8'h00);
    settle(1);
    chk({31'h0, idle_flag_o}, 32'h1);
    tick(40);
    settle(3);
    chk(32'(resets), 32'h1);
    @(posedge core_clk_i);
    port3_pin3_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    port3_pin3_i <= 1'b0;
    settle(5);
    chk({31'h0, idle_flag_o}, 32'h1);
    @(posedge core_clk_i);
    port3_pin3_i <= 1'b1;
    repeat (IDLE_N + 10) @(posedge core_clk_i);
    port3_pin3_i <= 1'b0;
    settle(1);
    chk({31'h0, idle_flag_o}, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 8'h02);
    wr(OFS_IRQ_STATUS, 8'h03);
    tick(31);
    settle(3);
    chk(32'(resets), 32'h1);
    tick(1);
    settle(3);
    chk(32'(resets), 32'h2);
  endtask

  task automatic t_usb_wd();
    wr(OFS_WATCHDOG_CONTROL_STATUS, 8'h80);
    tick(20);
    usb(1'b0);
    rd_chk(OFS_WATCHDOG_CONTROL_STATUS, 8'h80);
    tick(31);
    settle(3);
    chk(32'(resets), 32'h2);
    usb(1'b1);
    rd_chk(OFS_WATCHDOG_CONTROL_STATUS, 8'h00);
  endtask

  task automatic t_refused();
    rd_chk(6'h3c, 8'h00);
    wr(6'h3c, 8'hff);
    rd_chk(6'h3c, 8'h00);
    avs_byteenable_i <= 4'h0;
    wr(OFS_INT_DELAY, 8'h05);
    avs_byteenable_i <= 4'hf;
    rd_chk(OFS_INT_DELAY, 8'h0f);
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    t_config_map();
    t_pullup_delay();
    t_irq_src();
    t_wdt();
    t_idle();
    t_usb_wd();
    t_refused();
    complete_run();
  end
endmodule

`default_nettype wire
